// File: rtl/acss_pkg.sv
// constants, types and helpers for the audio clock source select block
package acss_pkg;
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_RATE      = 4'h1;
	localparam logic [3:0]  ADDR_PITCH     = 4'h2;
	localparam logic [3:0]  ADDR_PITCH_CMD = 4'h3;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam logic [3:0]  ADDR_DET_RATE  = 4'h5;
	localparam logic [3:0]  ADDR_CUR_RATE  = 4'h6;
	localparam int          CTRL_W         = 10;
	localparam logic [9:0]  CTRL_RST       = 10'h000;
	localparam logic [3:0]  RATE_RST       = 4'h1;
	localparam logic [3:0]  RATE_NONE      = 4'hf;
	localparam logic [3:0]  RATE_DOUBLE    = 4'h3;
	localparam logic [3:0]  RATE_QUAD      = 4'h6;
	localparam logic [3:0]  RATE_LAST      = 4'h8;
	localparam logic [17:0] BASE_TOP_HZ    = 18'h0bb80;
	localparam logic [17:0] FINE_STEP_HZ   = 18'h00001;
	localparam logic [17:0] COARSE_STEP_HZ = 18'h00032;
	localparam logic [17:0] LIMIT_DIV      = 18'h00014;
	localparam logic [17:0] PULL_SMALL_DIV = 18'h003e8;
	localparam logic [17:0] PULL_LARGE_DIV = 18'h00019;
	// period of one input frame in 50 ns cycles; beyond this the input is lost
	localparam logic [9:0]  PERIOD_TIMEOUT = 10'h2d0;
	localparam logic [9:0]  PERIOD_MIN     = 10'h05a;
	// 2^46 / 20 MHz, so that rate times this shifted by 14 is a 32-bit phase step
	localparam logic [21:0] DDS_MULT       = 22'h35afe5;
	localparam int          DDS_SHIFT      = 14;

	typedef enum logic [2:0] {SRC_INTERNAL, SRC_WORD, SRC_COAX, SRC_AES, SRC_OPTICAL} acss_src_e;
	typedef enum logic [1:0] {LINK_NONE, LINK_LOCK, LINK_SYNC} acss_link_e;
	typedef enum logic [3:0] {PC_NONE, PC_FINE_UP, PC_FINE_DN, PC_COARSE_UP, PC_COARSE_DN,
		PC_RESET, PC_SMALL_UP, PC_SMALL_DN, PC_LARGE_UP, PC_LARGE_DN} acss_pcmd_e;

	typedef struct packed {
		logic [2:0] src_sel;
		logic       wclk_out_en;
		logic       cs_pass;
		logic       loopback;
		logic       rec_proc;
		logic       coax_pro;
		logic       opt_spdif;
		logic       wclk_base;
	} acss_ctrl_s;

	typedef struct packed {
		logic       opt_spdif;
		logic       opt_cs_pro;
		logic       coax_cs_pro;
		logic       rec_from_input;
		logic       rec_from_output;
		logic       cs_forward;
		logic [2:0] opt_slots;
		logic [3:0] opt_chans;
	} acss_fmt_s;

	function automatic logic [17:0] acss_nominal(input logic [3:0] c);
		unique case (c)
			4'h0: acss_nominal = 18'h07d00;
			4'h1: acss_nominal = 18'h0ac44;
			4'h2: acss_nominal = 18'h0bb80;
			4'h3: acss_nominal = 18'h0fa00;
			4'h4: acss_nominal = 18'h15888;
			4'h5: acss_nominal = 18'h17700;
			4'h6: acss_nominal = 18'h1f400;
			4'h7: acss_nominal = 18'h2b110;
			4'h8: acss_nominal = 18'h2ee00;
			default: acss_nominal = 18'h00000;
		endcase
	endfunction

	// lower period bound of classes 0 to 7, midway between neighbouring nominal periods
	function automatic logic [3:0] acss_classify(input logic [9:0] p);
		if (p >= PERIOD_TIMEOUT || p < PERIOD_MIN) acss_classify = RATE_NONE;
		else if (p >= 10'h21b) acss_classify = 4'h0;
		else if (p >= 10'h1b3) acss_classify = 4'h1;
		else if (p >= 10'h16d) acss_classify = 4'h2;
		else if (p >= 10'h10e) acss_classify = 4'h3;
		else if (p >= 10'h0da) acss_classify = 4'h4;
		else if (p >= 10'h0b7) acss_classify = 4'h5;
		else if (p >= 10'h087) acss_classify = 4'h6;
		else if (p >= 10'h06d) acss_classify = 4'h7;
		else acss_classify = 4'h8;
	endfunction
endpackage

// File: rtl/acss_top.sv
// clock source selection, input monitoring, pitch synthesis and output format control
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module acss_top
	import acss_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        transport_active,
	input  wire logic [3:0]  ext_clk,
	output logic             wclk_out,
	output logic             wclk_drive_en,
	output acss_src_e        active_src,
	output acss_fmt_s        fmt
);
	acss_ctrl_s         ctrl;
	logic [3:0]         rate_code;
	logic signed [15:0] pitch;
	logic [3:0]         sync1;
	logic [3:0]         sync2;
	logic [3:0]         sync3;
	logic [9:0]         per_cnt [4];
	logic [3:0]         det_class [4];
	logic [3:0]         prev_class [4];
	logic [3:0]         locked;
	acss_link_e         link [4];
	acss_src_e          next_src;
	logic [3:0]         cur_code;
	logic [17:0]        base_hz;
	logic [17:0]        limit_hz;
	logic signed [15:0] pitch_eff;
	logic signed [15:0] next_pitch;
	logic signed [18:0] int_rate;
	logic [17:0]        cur_rate_hz;
	logic [17:0]        wclk_rate_hz;
	logic [39:0]        wclk_prod;
	logic [31:0]        wclk_acc;
	logic               sel_ext;
	logic [1:0]         sel_idx;

	function automatic logic signed [15:0] clamp(input logic signed [16:0] v,
		input logic [17:0] lim);
		logic signed [16:0] l;
		l = $signed({2'b00, lim[14:0]});
		if (v > l) clamp = l[15:0];
		else if (v < -l) clamp = 16'((-l));
		else clamp = v[15:0];
	endfunction

	// software writes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl <= CTRL_RST;
		end else if (wr && addr == ADDR_CTRL) begin
			ctrl <= wdata[CTRL_W-1:0];
		end
	end

	// a rate change mid-stream would glitch the audio, so it is simply dropped
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rate_code <= RATE_RST;
		end else if (wr && addr == ADDR_RATE && !transport_active && wdata[3:0] <= RATE_LAST) begin
			rate_code <= wdata[3:0];
		end
	end

	assign base_hz  = acss_nominal(rate_code);
	assign limit_hz = base_hz / LIMIT_DIV;

	always_comb begin
		next_pitch = pitch;
		if (wr && addr == ADDR_PITCH) begin
			next_pitch = clamp(17'(signed'(wdata[15:0])), limit_hz);
		end else if (wr && addr == ADDR_PITCH_CMD) begin
			unique case (wdata[3:0])
				PC_FINE_UP:   next_pitch = clamp(17'(pitch) + 17'(FINE_STEP_HZ), limit_hz);
				PC_FINE_DN:   next_pitch = clamp(17'(pitch) - 17'(FINE_STEP_HZ), limit_hz);
				PC_COARSE_UP: next_pitch = clamp(17'(pitch) + 17'(COARSE_STEP_HZ), limit_hz);
				PC_COARSE_DN: next_pitch = clamp(17'(pitch) - 17'(COARSE_STEP_HZ), limit_hz);
				PC_RESET:     next_pitch = 16'h0000;
				PC_SMALL_UP:  next_pitch = 16'(base_hz / PULL_SMALL_DIV);
				PC_SMALL_DN:  next_pitch = -16'(base_hz / PULL_SMALL_DIV);
				PC_LARGE_UP:  next_pitch = 16'(base_hz / PULL_LARGE_DIV);
				PC_LARGE_DN:  next_pitch = -16'(base_hz / PULL_LARGE_DIV);
				default:      next_pitch = pitch;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pitch <= 16'h0000;
		end else begin
			pitch <= next_pitch;
		end
	end

	// input monitors: external clocks are sampled, never used as clocks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
		end else begin
			sync1 <= ext_clk;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	generate
		for (genvar i = 0; i < 4; i++) begin : g_mon
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					per_cnt[i]    <= 10'h000;
					det_class[i]  <= RATE_NONE;
					prev_class[i] <= RATE_NONE;
					locked[i]     <= 1'b0;
				end else if (sync2[i] && !sync3[i]) begin
					per_cnt[i]    <= 10'h001;
					prev_class[i] <= acss_classify(per_cnt[i]);
					det_class[i]  <= acss_classify(per_cnt[i]);
					// two matching periods in a row before lock, to reject a lone glitch
					locked[i]     <= acss_classify(per_cnt[i]) != RATE_NONE
						&& acss_classify(per_cnt[i]) == prev_class[i];
				end else if (per_cnt[i] >= PERIOD_TIMEOUT) begin
					det_class[i]  <= RATE_NONE;
					prev_class[i] <= RATE_NONE;
					locked[i]     <= 1'b0;
				end else begin
					per_cnt[i]    <= per_cnt[i] + 10'h001;
				end
			end
			assign link[i] = !locked[i] ? LINK_NONE :
				(det_class[i] == cur_code ? LINK_SYNC : LINK_LOCK);
		end
	endgenerate

	// source choice
	assign sel_ext = ctrl.src_sel >= 3'(SRC_WORD) && ctrl.src_sel <= 3'(SRC_OPTICAL);
	assign sel_idx = 2'(ctrl.src_sel - 3'(SRC_WORD));

	always_comb begin
		next_src = SRC_INTERNAL;
		if (sel_ext && locked[sel_idx]) begin
			next_src = acss_src_e'(ctrl.src_sel);
		end else if (sel_ext) begin
			if (locked[0]) next_src = SRC_WORD;
			else if (locked[1]) next_src = SRC_COAX;
			else if (locked[2]) next_src = SRC_AES;
			else if (locked[3]) next_src = SRC_OPTICAL;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			active_src <= SRC_INTERNAL;
		end else begin
			active_src <= next_src;
		end
	end

	// rate in use; the offset exists only while running as master
	assign pitch_eff = clamp(17'(pitch), limit_hz);
	assign int_rate  = $signed({1'b0, base_hz}) + 19'(pitch_eff);
	assign cur_code  = active_src == SRC_INTERNAL ? rate_code :
		det_class[2'(3'(active_src) - 3'(SRC_WORD))];
	assign cur_rate_hz = active_src == SRC_INTERNAL ? int_rate[17:0] : acss_nominal(cur_code);

	always_comb begin
		wclk_rate_hz = cur_rate_hz;
		if (ctrl.wclk_base && cur_code != RATE_NONE && cur_code >= RATE_QUAD) begin
			wclk_rate_hz = cur_rate_hz >> 2;
		end else if (ctrl.wclk_base && cur_code != RATE_NONE && cur_code >= RATE_DOUBLE) begin
			wclk_rate_hz = cur_rate_hz >> 1;
		end
	end

	// phase accumulator: one adder, no divider, at the price of 50 ns edge jitter
	assign wclk_prod = wclk_rate_hz * DDS_MULT;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wclk_acc <= 32'h00000000;
			wclk_out <= 1'b0;
		end else begin
			wclk_acc <= wclk_acc + {6'h00, wclk_prod[DDS_SHIFT+25:DDS_SHIFT]};
			wclk_out <= wclk_acc[31];
		end
	end

	// output format and path control
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wclk_drive_en <= 1'b0;
			fmt           <= '0;
		end else begin
			wclk_drive_en       <= ctrl.wclk_out_en;
			fmt.opt_spdif       <= ctrl.opt_spdif;
			fmt.opt_cs_pro      <= 1'b0;
			fmt.coax_cs_pro     <= ctrl.coax_pro;
			fmt.rec_from_input  <= ctrl.rec_proc && !ctrl.loopback;
			fmt.rec_from_output <= ctrl.rec_proc && ctrl.loopback;
			fmt.cs_forward      <= ctrl.cs_pass;
			if (ctrl.opt_spdif) begin
				fmt.opt_slots <= 3'h1;
				fmt.opt_chans <= 4'h2;
			end else if (cur_code != RATE_NONE && cur_code >= RATE_QUAD) begin
				fmt.opt_slots <= 3'h4;
				fmt.opt_chans <= 4'h2;
			end else if (cur_code != RATE_NONE && cur_code >= RATE_DOUBLE) begin
				fmt.opt_slots <= 3'h2;
				fmt.opt_chans <= 4'h4;
			end else begin
				fmt.opt_slots <= 3'h1;
				fmt.opt_chans <= 4'h8;
			end
		end
	end

	// read port
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			unique case (addr)
				ADDR_CTRL:     rdata <= {22'h000000, ctrl};
				ADDR_RATE:     rdata <= {28'h0000000, rate_code};
				ADDR_PITCH:    rdata <= {{16{pitch[15]}}, pitch};
				ADDR_STATUS:   rdata <= {20'h00000, link[3], link[2], link[1], link[0],
					transport_active, active_src};
				ADDR_DET_RATE: rdata <= {16'h0000, det_class[3], det_class[2], det_class[1],
					det_class[0]};
				ADDR_CUR_RATE: rdata <= {14'h0000, cur_rate_hz};
				default:       rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// checks
	chk_wclk_dir: assert property (@(posedge clock) disable iff (!resetn)
		(wr && addr == ADDR_CTRL) |=> ##1 wclk_drive_en == $past(wdata[6], 2))
		else $error("word clock connector direction wrong");
	chk_rate_refuse: assert property (@(posedge clock) disable iff (!resetn)
		(wr && addr == ADDR_RATE && transport_active) |=> rate_code == $past(rate_code))
		else $error("rate changed during transport");
	chk_src_internal: assert property (@(posedge clock) disable iff (!resetn)
		(locked == 4'h0) |=> active_src == SRC_INTERNAL)
		else $error("no valid input yet not internal");
	chk_fallback_order: assert property (@(posedge clock) disable iff (!resetn)
		(sel_ext && !locked[sel_idx] && locked[0]) |=> active_src == SRC_WORD)
		else $error("fallback skipped word clock");
	chk_sel_kept: assert property (@(posedge clock) disable iff (!resetn)
		(sel_ext && locked[sel_idx]) |=> 3'(active_src) == $past(ctrl.src_sel))
		else $error("valid selected source not used");
	chk_opt_consumer: assert property (@(posedge clock) disable iff (!resetn)
		fmt.opt_spdif |-> !fmt.opt_cs_pro && fmt.opt_chans == 4'h2)
		else $error("optical spdif not consumer");
	chk_wclk_base: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl.wclk_base && active_src != SRC_INTERNAL) |-> wclk_rate_hz <= BASE_TOP_HZ)
		else $error("word clock above base range");
	chk_wclk_follow: assert property (@(posedge clock) disable iff (!resetn)
		!ctrl.wclk_base |-> wclk_rate_hz == cur_rate_hz)
		else $error("word clock not at sample rate");
	chk_pitch_limit: assert property (@(posedge clock) disable iff (!resetn)
		active_src == SRC_INTERNAL |-> int_rate <= $signed({1'b0, base_hz + limit_hz})
		&& int_rate >= $signed({1'b0, base_hz - limit_hz}))
		else $error("pitch beyond limit");
	chk_offset_master: assert property (@(posedge clock) disable iff (!resetn)
		active_src != SRC_INTERNAL |-> cur_rate_hz == acss_nominal(cur_code))
		else $error("offset applied while slaved");
	chk_lock_timeout: assert property (@(posedge clock) disable iff (!resetn)
		(per_cnt[0] >= PERIOD_TIMEOUT && !(sync2[0] && !sync3[0])) |=> !locked[0])
		else $error("lock kept without edges");
	chk_coarse_step: assert property (@(posedge clock) disable iff (!resetn)
		(wr && addr == ADDR_PITCH_CMD && wdata[3:0] == PC_COARSE_UP
		&& 17'(pitch) + 17'(COARSE_STEP_HZ) <= $signed({2'b00, limit_hz[14:0]}))
		|=> pitch == $past(pitch) + 16'(COARSE_STEP_HZ))
		else $error("coarse step wrong");
	cov_fallback: cover property (@(posedge clock) disable iff (!resetn)
		sel_ext && !locked[sel_idx] && active_src != SRC_INTERNAL);
	cov_lock_word: cover property (@(posedge clock) disable iff (!resetn)
		$rose(locked[0]));
	cov_pitch_up: cover property (@(posedge clock) disable iff (!resetn)
		wr && addr == ADDR_PITCH_CMD && wdata[3:0] == PC_COARSE_UP ##1 pitch > 16'sh0000);
endmodule // acss_top
`default_nettype wire

// File: verification/acss_ext_src.sv
// behavioural model of external equipment feeding frame clocks to the four inputs
`timescale 1ns/10ps
`default_nettype none
module acss_ext_src (
	input  wire logic [3:0]  run,
	input  wire logic [15:0] half_ns [4],
	output var logic  [3:0]  ext_clk
);
	// a stopped source holds its line low: an unplugged input idles, it does not keep toggling
	for (genvar i = 0; i < 4; i++) begin : g_src
		initial begin
			ext_clk[i] = 1'b0;
			#(13 * i + 7);
			forever begin
				if (run[i]) begin
					#(half_ns[i]);
					ext_clk[i] = ~ext_clk[i];
				end else begin
					ext_clk[i] = 1'b0;
					#100;
				end
			end
		end
	end
endmodule // acss_ext_src
`default_nettype wire

// File: verification/tb_audio_clock_source_select.sv
// self-checking bench for the audio clock source select block
`timescale 1ns/10ps
`default_nettype none
module tb_audio_clock_source_select;
	import acss_pkg::*;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	// host side: transport stays idle across every rate write of the bench but one, which is refused
	logic        transport_active = 1'b0;
	logic [31:0] rdata;
	logic [3:0]  ext_clk;
	logic [3:0]  link_run = 4'h0;
	logic [15:0] link_half [4] = '{16'h00c8, 16'h28a0, 16'h2c4c, 16'h28a0};
	logic        wclk_out;
	logic        wclk_drive_en;
	acss_src_e   active_src;
	acss_fmt_s   fmt;
	int          fails = 0;
	int          samples_checked = 0;
	logic [31:0] got;
	int          n;
	logic [9:0]  row_ctrl [9] = '{10'h000, 10'h002, 10'h004, 10'h008, 10'h018, 10'h020,
		10'h040, 10'h03c, 10'h041};
	logic [17:0] row_hz [9] = '{18'h07d00, 18'h0ac44, 18'h0bb80, 18'h0fa00, 18'h15888,
		18'h17700, 18'h1f400, 18'h2b110, 18'h2ee00};
	logic [12:0] row_fmt [9] = '{13'h0018, 13'h1012, 13'h0418, 13'h0224, 13'h0124, 13'h00a4,
		13'h0042, 13'h05c2, 13'h0042};
	logic [8:0]  row_drv = 9'h140;
	logic [3:0]  wk_code [5] = '{4'h2, 4'h8, 4'h5, 4'h8, 4'h0};
	logic [4:0]  wk_base = 5'h1c;
	int          wk_exp [5] = '{24, 96, 24, 24, 16};
	logic [3:0]  pc_cmd [10] = '{4'h5, 4'h1, 4'h3, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9, 4'h8, 4'h5};
	// presets load an absolute offset, they do not add to the one in place
	logic [31:0] pc_exp [10] = '{32'h0, 32'h1, 32'h33, 32'h32, 32'h0, 32'h30, 32'hffffffd0,
		32'hfffff880, 32'h780, 32'h0};
	acss_src_e   src_exp [4] = '{SRC_COAX, SRC_COAX, SRC_AES, SRC_OPTICAL};

	always #25 clock = ~clock;

	acss_top u_acss_top (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .transport_active(transport_active), .ext_clk(ext_clk),
		.wclk_out(wclk_out), .wclk_drive_en(wclk_drive_en), .active_src(active_src), .fmt(fmt));

	acss_ext_src u_acss_ext_src (.run(link_run), .half_ns(link_half), .ext_clk(ext_clk));

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_near(input int g, input int e);
		samples_checked++;
		if (g < e - 1 || g > e + 1) begin
			fails++;
			$display("[ERR] %0t count %0d expected %0d", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so they are taken there
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 got = rdata;
		chk(got, e);
	endtask

	task automatic wait_src(input acss_src_e e);
		int k;
		for (k = 0; k < 4000 && active_src !== e; k++) @(posedge clock);
		if (k == 4000) begin
			fails++;
			$display("[ERR] %0t source wait ran out", $time);
			complete_run();
		end
		chk({29'h0, active_src}, {29'h0, e});
	endtask

	task automatic wclk_count(output int c);
		logic prev;
		c = 0;
		prev = wclk_out;
		repeat (10000) begin
			@(posedge clock);
			if (wclk_out === 1'b1 && prev === 1'b0) c++;
			prev = wclk_out;
		end
	endtask

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
	endtask

	initial begin
		do_reset();
		@(posedge clock);
		chk({19'h0, fmt}, 32'h0018);
		chk({31'h0, wclk_drive_en}, 32'h0);
		chk({29'h0, active_src}, {29'h0, SRC_INTERNAL});
		rd_chk(4'h7, 32'h0);
		@(posedge clock);
		#1 chk(rdata, 32'h0);
		for (int i = 0; i < 9; i++) begin
			wr_reg(ADDR_CTRL, {22'h0, row_ctrl[i]});
			wr_reg(ADDR_RATE, 32'(i));
			repeat (2) @(posedge clock);
			chk({19'h0, fmt}, {19'h0, row_fmt[i]});
			chk({31'h0, wclk_drive_en}, {31'h0, row_drv[i]});
			rd_chk(ADDR_CTRL, {22'h0, row_ctrl[i]});
			rd_chk(ADDR_CUR_RATE, {14'h0, row_hz[i]});
		end
		transport_active <= 1'b1;
		wr_reg(ADDR_RATE, 32'h2);
		transport_active <= 1'b0;
		rd_chk(ADDR_RATE, 32'h8);
		wr_reg(ADDR_RATE, 32'h9);
		wr_reg(ADDR_STATUS, 32'hffffffff);
		wr_reg(4'hb, 32'hffffffff);
		rd_chk(ADDR_RATE, 32'h8);
		rd_chk(4'hb, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ADDR_CTRL, {31'h0, wk_base[i]});
			wr_reg(ADDR_RATE, {28'h0, wk_code[i]});
			repeat (20) @(posedge clock);
			wclk_count(n);
			chk_near(n, wk_exp[i]);
		end
		wr_reg(ADDR_CTRL, 32'h0);
		wr_reg(ADDR_RATE, 32'h2);
		for (int i = 0; i < 10; i++) begin
			wr_reg(ADDR_PITCH_CMD, {28'h0, pc_cmd[i]});
			rd_chk(ADDR_PITCH, pc_exp[i]);
		end
		wr_reg(ADDR_PITCH_CMD, 32'h6);
		rd_chk(ADDR_CUR_RATE, 32'hbbb0);
		wr_reg(ADDR_PITCH, 32'h7fff);
		rd_chk(ADDR_PITCH, 32'h960);
		wr_reg(ADDR_PITCH_CMD, 32'h3);
		rd_chk(ADDR_PITCH, 32'h960);
		rd_chk(ADDR_CUR_RATE, 32'hc4e0);
		wr_reg(ADDR_PITCH, 32'h8000);
		rd_chk(ADDR_PITCH, 32'hfffff6a0);
		wr_reg(ADDR_PITCH, 32'h960);
		// word input runs at the 400 ns link rate, far above any audio rate, so it counts as lost
		link_run <= 4'hf;
		for (int i = 0; i < 4; i++) begin
			wr_reg(ADDR_CTRL, 32'(i + 1) << 7);
			wait_src(src_exp[i]);
		end
		wr_reg(ADDR_CTRL, 32'h80);
		wait_src(SRC_COAX);
		rd_chk(ADDR_STATUS, 32'h982);
		rd_chk(ADDR_DET_RATE, 32'h212f);
		rd_chk(ADDR_CUR_RATE, 32'hbb80);
		link_run <= 4'h0;
		wait_src(SRC_INTERNAL);
		rd_chk(ADDR_STATUS, 32'h0);
		do_reset();
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_RATE, 32'h1);
		rd_chk(ADDR_PITCH, 32'h0);
		complete_run();
	end
endmodule // tb_audio_clock_source_select
`default_nettype wire
